// [etc_classifier.sv]
// Excitation type classifier: energy stability to sound category
`timescale 1ns/1ps
module etc_classifier
  import etc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        frame_i,
  input  wire logic [15:0] energy_i,
  input  wire logic        erasure_i,
  input  wire logic        vad_valid_i,
  input  wire logic        vad_active_i,
  input  wire logic        generic_audio_coding_flag_i,
  output logic             busy_o,
  output logic             done_o,
  output etc_result_t      result_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Step back n entries in the 40 deep ring
  function automatic logic [5:0] ring_back(logic [5:0] p, logic [5:0] n);
    // Sum may pass 63 on the way, the 6 bit result still lands right
    return (p >= n) ? p - n : p + AVG_LEN_W - n;
  endfunction

  // Squared deviation below squared threshold, no square root needed
  function automatic logic below_thr(logic [51:0] acc, logic [15:0] t);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(acc) * 64'(DEV_P2_Q8);
    rhs = 64'(t) * 64'(t) * 64'(DEV_SCALE);
    return lhs < rhs;
  endfunction

  // Keep a threshold inside its absolute limits
  function automatic logic [15:0] thr_clamp(logic [16:0] v,
                                            logic [15:0] lo,
                                            logic [15:0] hi);
    return (v < {1'b0, lo}) ? lo : (v > {1'b0, hi}) ? hi : v[15:0];
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  etc_state_t          st_r;
  logic signed [16:0]  hist_r [AVG_LEN];
  logic [5:0]          wr_ptr_r;
  logic signed [22:0]  sum_r;
  logic signed [15:0]  prev_en_r;
  logic [4:0]          k_r;
  logic [51:0]         acc_r;
  logic                force_r;
  logic [1:0]          hold_r;
  etc_thr_t            thr_r;
  logic [4:0]          run34_r;
  logic [4:0]          run0_r;
  etc_result_t         result_r;
  logic                done_r;

  logic                take;
  logic signed [16:0]  diff;
  logic signed [16:0]  hsel;
  logic signed [23:0]  dev;
  logic [47:0]         dev_sq;
  logic [3:0]          lt;
  logic [2:0]          cat_nxt;
  logic [4:0]          run34_nxt;
  logic [4:0]          run0_nxt;

  assign take   = ce_i && frame_i && (st_r == S_IDLE);
  assign busy_o = (st_r != S_IDLE);
  assign done_o = done_r;
  assign result_o = result_r;
  // Upstream energy is already in dB; only its difference is kept
  assign diff = 17'(signed'(energy_i)) - 17'(prev_en_r);

  // ****************************************************************
  // Difference history and running sum
  // ****************************************************************

  // Sum kept incrementally so the average costs one add per frame
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r  <= 6'h00;
      sum_r     <= 23'sh000000;
      prev_en_r <= 16'sh0000;
      for (int i = 0; i < AVG_LEN; i++) begin
        hist_r[i] <= 17'sh00000;
      end
    end else if (take) begin
      prev_en_r <= signed'(energy_i);
      sum_r     <= sum_r + 23'(diff) - 23'(hist_r[wr_ptr_r]);
      hist_r[wr_ptr_r] <= diff;
      wr_ptr_r  <= ring_back(wr_ptr_r, AVG_LEN_W - 6'h01);
    end
  end

  // ****************************************************************
  // Deviation accumulation, one history entry per cycle
  // ****************************************************************

  // Scaled by 40 so the average needs no divider
  assign hsel   = hist_r[ring_back(wr_ptr_r, {1'b0, k_r} + 6'h01)];
  assign dev    = 24'(hsel) * 24'sd40 - 24'(sum_r);
  assign dev_sq = 48'(dev) * 48'(dev);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r  <= S_IDLE;
      k_r   <= 5'h00;
      acc_r <= 52'h0;
    end else if (ce_i) begin
      case (st_r)
        S_IDLE: begin
          if (frame_i) begin
            st_r  <= S_ACC;
            k_r   <= 5'h00;
            acc_r <= 52'h0;
          end
        end
        S_ACC: begin
          acc_r <= acc_r + 52'(dev_sq);
          k_r   <= k_r + 5'h01;
          if (k_r == DEV_LAST) begin
            st_r <= S_DECIDE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Category decision
  // ****************************************************************

  // Previous category is the registered result itself
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lt[i] = below_thr(acc_r, thr_r[i]);
    end
    cat_nxt = 3'h0;
    if (force_r || (hold_r != 2'h0)) begin
      cat_nxt = 3'h0;
    end else if (lt[3] && result_r.cat >= 3'h3) begin
      cat_nxt = 3'h4;
    end else if (lt[2] && result_r.cat >= 3'h2) begin
      cat_nxt = 3'h3;
    end else if (lt[1] && result_r.cat >= 3'h1) begin
      cat_nxt = 3'h2;
    end else if (lt[0]) begin
      cat_nxt = 3'h1;
    end
    run34_nxt = (cat_nxt >= 3'h3) ? run34_r + 5'h01 : 5'h00;
    run0_nxt  = (cat_nxt == 3'h0) ? run0_r + 5'h01 : 5'h00;
  end

  // Forcing flags are caught with the frame, erasure holds 3 frames
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_r <= 1'b0;
      hold_r  <= 2'h0;
    end else if (take) begin
      force_r <= (vad_valid_i && !vad_active_i) ||
                 !generic_audio_coding_flag_i;
      if (erasure_i) begin
        hold_r <= ERASE_HOLD;
      end
    end else if (ce_i && st_r == S_DECIDE && hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // Table lookup on the decided category, done pulses one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_r <= '0;
      done_r   <= 1'b0;
    end else if (ce_i) begin
      done_r <= (st_r == S_DECIDE);
      if (st_r == S_DECIDE) begin
        case (cat_nxt)
          3'h1:    result_r <= '{3'h1, RED_CAT1, 1'b1, BAND_510};
          3'h2:    result_r <= '{3'h2, RED_CAT2, 1'b1, BAND_510};
          3'h3:    result_r <= '{3'h3, RED_CAT34, 1'b1, BAND_400};
          3'h4:    result_r <= '{3'h4, RED_CAT34, 1'b1, BAND_300};
          default: result_r <= '{3'h0, RED_CAT0, 1'b0, 10'h000};
        endcase
      end
    end
  end

  // ****************************************************************
  // Floating thresholds and run counters
  // ****************************************************************

  // Counter restarts after each step so steps come every 31 frames
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thr_r   <= THR_INIT;
      run34_r <= 5'h00;
      run0_r  <= 5'h00;
    end else if (take && erasure_i) begin
      thr_r <= THR_MIN;
    end else if (ce_i && st_r == S_DECIDE) begin
      run34_r <= run34_nxt;
      run0_r  <= run0_nxt;
      if (run34_nxt > RUN_LIMIT) begin
        run34_r <= 5'h00;
        for (int i = 0; i < 4; i++) begin
          thr_r[i] <= thr_clamp({1'b0, thr_r[i]} + {1'b0, THR_STEP},
                                THR_MIN[i], THR_MAX[i]);
        end
      end else if (run0_nxt > RUN_LIMIT) begin
        run0_r <= 5'h00;
        for (int i = 0; i < 4; i++) begin
          thr_r[i] <= thr_clamp({1'b0, thr_r[i]} - {1'b0, THR_STEP},
                                THR_MIN[i], THR_MAX[i]);
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i || !ce_i);

  sequence acc_run;
    (st_r == S_ACC)[*8] ##1 (st_r == S_ACC)[*7];
  endsequence

  a_acc_length: assert property (take |=> acc_run ##1 st_r == S_DECIDE ##1 done_o)
    else $error("deviation pass length wrong");
  a_sum_track: assert property (take |=> sum_r == $past(sum_r)
      + 23'($past(diff)) - 23'($past(hist_r[wr_ptr_r])))
    else $error("running sum wrong");
  a_cat_zero: assert property (done_o && result_o.cat == 3'h0 |->
      result_o.reduction_db == RED_CAT0 && !result_o.band_valid)
    else $error("category 0 table wrong");
  a_cat_low: assert property (done_o && result_o.cat inside {3'h1, 3'h2}
      |-> result_o.band_start_hz == BAND_510)
    else $error("category 1/2 band wrong");
  a_cat_high: assert property (done_o && result_o.cat >= 3'h3 |->
      result_o.reduction_db == RED_CAT34)
    else $error("category 3/4 reduction wrong");
  a_cat_climb: assert property (st_r == S_DECIDE |=>
      {1'b0, result_o.cat} <= {1'b0, $past(result_o.cat)} + 4'h1)
    else $error("category climbed too fast");
  a_force_zero: assert property (st_r == S_DECIDE &&
      (force_r || hold_r != 2'h0) |=> result_o.cat == 3'h0)
    else $error("forced category not zero");
  a_erase_min: assert property (take && erasure_i |=>
      thr_r == THR_MIN ##16 result_o.cat == 3'h0)
    else $error("erasure handling wrong");
  a_thr_clamp: assert property (thr_r[0] >= THR_MIN[0] &&
      thr_r[0] <= THR_MAX[0] && thr_r[3] >= THR_MIN[3] &&
      thr_r[3] <= THR_MAX[3])
    else $error("threshold out of limits");
  a_thr_raise: assert property (thr_r[0] > $past(thr_r[0]) |->
      $past(run34_r) == RUN_LIMIT)
    else $error("threshold raised without run");
  a_thr_lower: assert property (thr_r[0] < $past(thr_r[0]) &&
      !$past(take) |-> $past(run0_r) == RUN_LIMIT)
    else $error("threshold lowered without run");

endmodule

// [etc_classifier_tb.sv]
// Self-checking testbench of the excitation type classifier
`timescale 1ns/1ps
module etc_classifier_tb;
  import etc_pkg::*;
  logic        clk_i;
  logic        nrst_i;
  logic        ce_i;
  logic        frame_i;
  logic [15:0] energy_i;
  logic        erasure_i;
  logic        vad_valid_i;
  logic        vad_active_i;
  logic        gac_i;
  logic        busy_o;
  logic        done_o;
  etc_result_t result_o;
  int          errors;
  int          checks_done;
  // Flags {erasure, vad valid, vad active, generic audio}
  localparam logic [3:0] OK = 4'h1;

  etc_classifier u_dut (
    .clk_i                       (clk_i),
    .nrst_i                      (nrst_i),
    .ce_i                        (ce_i),
    .frame_i                     (frame_i),
    .energy_i                    (energy_i),
    .erasure_i                   (erasure_i),
    .vad_valid_i                 (vad_valid_i),
    .vad_active_i                (vad_active_i),
    .generic_audio_coding_flag_i (gac_i),
    .busy_o                      (busy_o),
    .done_o                      (done_o),
    .result_o                    (result_o)
  );

  etc_upstream u_src (
    .clk_i        (clk_i),
    .busy_i       (busy_o),
    .frame_o      (frame_i),
    .energy_o     (energy_i),
    .erasure_o    (erasure_i),
    .vad_valid_o  (vad_valid_i),
    .vad_active_o (vad_active_i),
    .gac_flag_o   (gac_i)
  );

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Category table worked out independently of the design
  function automatic etc_result_t exp_res(input int c);
    etc_result_t r;
    r = '0;
    r.cat = 3'(c);
    r.band_valid = (c != 0);
    r.reduction_db = (c == 0) ? RED_CAT0 : (c == 1) ? RED_CAT1 :
                     (c == 2) ? RED_CAT2 : RED_CAT34;
    r.band_start_hz = (c == 0) ? 10'h0 : (c < 3) ? BAND_510 :
                      (c == 3) ? BAND_400 : BAND_300;
    return r;
  endfunction

  // One frame: send, wait for done (bounded), judge latency and result
  task automatic frame(input logic [15:0] e, input logic [3:0] fl,
                       input int cat, input int lat_exp);
    int lat;
    lat = 1; // Strobe cycle counts as the first
    u_src.send(e, fl, 1'b1);
    check(busy_o, 1'b1);
    while (done_o !== 1'b1 && lat < 60) begin
      @(negedge clk_i);
      lat++;
    end
    check(lat, lat_exp);
    check(result_o, exp_res(cat));
  endtask

  task automatic wrap_up();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({busy_o, done_o, result_o}, '0);
  endtask

  // Steady energy: zero deviation, category climbs one step a frame
  task automatic t_climb();
    for (int i = 1; i <= 6; i++) begin
      frame(16'h0, OK, (i > 4) ? 4 : i, 17);
    end
  endtask

  // A strobe while busy must leave no trace, not even in history
  task automatic t_refuse();
    int n;
    n = 0;
    fork
      frame(16'h0, OK, 4, 17);
      begin
        repeat (6) @(negedge clk_i);
        u_src.send(16'h7000, OK, 1'b0);
      end
    join
    repeat (25) begin
      @(negedge clk_i);
      n += int'(done_o === 1'b1);
    end
    check(n, 0);
    frame(16'h0, OK, 4, 17);
  endtask

  // Clock enable low for ten cycles stretches the answer by ten
  task automatic t_ce();
    fork
      frame(16'h0, OK, 4, 27);
      begin
        repeat (5) @(negedge clk_i);
        ce_i = 1'b0;
        repeat (10) @(negedge clk_i);
        ce_i = 1'b1;
      end
    join
  endtask

  // Silence and non generic frames force zero; missing VAD does not
  task automatic t_force();
    logic [3:0] fl[4];
    int         c[4];
    fl = '{4'h5, 4'h7, 4'h0, 4'h1};
    c = '{0, 1, 0, 1};
    for (int i = 0; i < 4; i++) begin
      frame(16'h0, fl[i], c[i], 17);
    end
  endtask

  // Erasure gives three zero frames counting the lost one
  task automatic t_erase();
    frame(16'h0, OK, 2, 17);
    frame(16'h0, 4'h9, 0, 17);
    frame(16'h0, OK, 0, 17);
    frame(16'h0, OK, 0, 17);
    frame(16'h0, OK, 1, 17);
  endtask

  // Long tonal run raises every threshold one step from its minimum
  task automatic t_raise();
    for (int i = 0; i < 32; i++) begin
      frame(16'h0, OK, (i == 0) ? 2 : (i == 1) ? 3 : 4, 17);
      if (i == 30) begin
        check(u_dut.thr_r[0], THR_MIN[0]);
      end
    end
    for (int j = 0; j < 4; j++) begin
      check(u_dut.thr_r[j], THR_MIN[j] + THR_STEP);
    end
  endtask

  // Large swings give category 0; the 31st in a row lowers thresholds
  task automatic t_swing();
    for (int i = 0; i < 32; i++) begin
      frame(i[0] ? 16'hc000 : 16'h4000, OK, 0, 17);
      if (i == 29) begin
        check(u_dut.thr_r[0], THR_MIN[0] + THR_STEP);
      end
    end
    for (int j = 0; j < 4; j++) begin
      check(u_dut.thr_r[j], THR_MIN[j]);
    end
  endtask

  // ****************************************************************
  // Clock, sequence and watchdog
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    errors = 0;
    checks_done = 0;
    nrst_i = 1'b0;
    ce_i = 1'b1;
    repeat (6) @(negedge clk_i);
    t_reset();
    nrst_i = 1'b1;
    t_climb();
    t_refuse();
    t_ce();
    t_force();
    t_erase();
    t_raise();
    t_swing();
    wrap_up();
  end

  // About 1500 cycles expected; cut at 5000
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule

// [etc_pkg.sv]
// Constants and carrier types of the excitation type classifier
package etc_pkg;

  // ****************************************************************
  // Energy history and deviation arithmetic
  // ****************************************************************
  localparam int          AVG_LEN     = 40;      // Frames in the average
  localparam int          DEV_LEN     = 15;      // Frames in the deviation
  localparam logic [5:0]  AVG_LEN_W   = 6'h28;   // 40 as a ring bound
  localparam logic [4:0]  DEV_LAST    = 5'h0e;   // Last deviation step
  localparam logic [7:0]  DEV_P2_Q8   = 8'h98;   // 0.77^2 in Q0.8
  // Threshold side scale: frames * 40^2 * 2^8 = 15 * 1600 * 256
  localparam logic [22:0] DEV_SCALE   = 23'h5dc000;

  // ****************************************************************
  // Floating thresholds, Q8.8 dB, index 0 is threshold 1
  // ****************************************************************
  typedef logic [3:0][15:0] etc_thr_t;
  localparam etc_thr_t THR_INIT = {16'h0100, 16'h0200, 16'h0300, 16'h0400};
  localparam etc_thr_t THR_MIN  = {16'h0080, 16'h0100, 16'h0180, 16'h0200};
  localparam etc_thr_t THR_MAX  = {16'h0200, 16'h0400, 16'h0600, 16'h0800};
  localparam logic [15:0] THR_STEP  = 16'h0020;
  localparam logic [4:0]  RUN_LIMIT = 5'h1e;     // Runs above 30 adjust
  localparam logic [1:0]  ERASE_HOLD = 2'h3;     // Frames forced to 0

  // ****************************************************************
  // Category table
  // ****************************************************************
  localparam logic [3:0] RED_CAT0  = 4'h0;
  localparam logic [3:0] RED_CAT1  = 4'h6;
  localparam logic [3:0] RED_CAT2  = 4'h9;
  localparam logic [3:0] RED_CAT34 = 4'hc;
  localparam logic [9:0] BAND_510  = 10'h1fe;
  localparam logic [9:0] BAND_400  = 10'h190;
  localparam logic [9:0] BAND_300  = 10'h12c;

  typedef enum logic [1:0] {S_IDLE, S_ACC, S_DECIDE} etc_state_t;

  typedef struct packed {
    logic [2:0] cat;           // Sound category 0..4
    logic [3:0] reduction_db;  // Allowed noise reduction
    logic       band_valid;    // Enhanced band present
    logic [9:0] band_start_hz; // Lowest enhanced frequency
  } etc_result_t;

endpackage

// [etc_upstream.sv]
// Upstream spectral stage model: frame energy, strobe and flags
`timescale 1ns/1ps
module etc_upstream (
  input  wire logic        clk_i,
  input  wire logic        busy_i,
  output logic             frame_o,
  output logic [15:0]      energy_o,
  output logic             erasure_o,
  output logic             vad_valid_o,
  output logic             vad_active_o,
  output logic             gac_flag_o
);
  // Idle values at time zero
  initial begin
    frame_o = 1'b0;
    energy_o = 16'h5a5a;
    {erasure_o, vad_valid_o, vad_active_o, gac_flag_o} = 4'h1;
  end

  // One strobe per call; idle=0 ignores busy to provoke a refusal
  task automatic send(input logic [15:0] e, input logic [3:0] fl,
                      input bit idle);
    @(negedge clk_i);
    while (idle && busy_i) @(negedge clk_i);
    frame_o = 1'b1;
    energy_o = e;
    {erasure_o, vad_valid_o, vad_active_o, gac_flag_o} = fl;
    @(negedge clk_i);
    frame_o = 1'b0;
    // Not held after the strobe, so a late sample sees garbage
    energy_o = ~e;
    {erasure_o, vad_valid_o, vad_active_o} = ~fl[3:1];
  endtask
endmodule
